/* File: verilog/ssmon_pkg.sv */
// Shared constants for the safing SPI monitor.
// Assumes a 16-bit sensor response frame and four monitored chip selects.
package ssmon_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int STAT_HI = 15;
  localparam int STAT_LO = 14;
  localparam int ORDER_HI = 13;
  localparam int ORDER_LO = 11;
  localparam int VALUE_HI = 9;
  localparam int VALUE_LO = 0;
  localparam logic [1:0] STAT_SENSOR = 2'h1;

  // ----------------------------------------------------------------
  // Counters and ranges
  // ----------------------------------------------------------------
  localparam logic [3:0] SEQ_RESET = 4'hf;
  localparam logic [3:0] SEQ_FROZEN = 4'he;
  localparam logic [3:0] SEQ_WIDE_LIMIT = 4'h2;
  localparam logic [3:0] VALID_RESET = 4'h0;
  localparam logic signed [9:0] NARROW_MIN = -10'sd480;
  localparam logic signed [9:0] NARROW_MAX = 10'sd480;
  localparam int NUM_SELECTS = 4;

  // ----------------------------------------------------------------
  // Thresholds and unlock
  // ----------------------------------------------------------------
  localparam int NUM_THRESH = 8;
  localparam logic [7:0] UNLOCK_MASK = 8'had;
  localparam logic [7:0] TH_DEF0 = 8'h0d;
  localparam logic [7:0] TH_DEF1 = 8'h95;
  localparam logic [7:0] TH_DEF2_5 = 8'h08;
  localparam logic [7:0] TH_DEF6_7 = 8'h04;
  localparam int DWELL_BIT = 7;

  // Safing state machine modes as seen by the monitor.
  localparam logic [2:0] MODE_STARTUP = 3'h0;
  localparam logic [2:0] MODE_SAFING = 3'h2;

endpackage : ssmon_pkg

/* File: verilog/ssmon_thresh_mem.sv */
// Eight-entry threshold store with defaults and registered read.
// Assumes write qualification is done by the caller.
`timescale 1ns/1ps
module ssmon_thresh_mem
  import ssmon_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [7:0] rd_data
);
  import ssmon_pkg::*;

  logic [7:0] mem_reg [NUM_THRESH];

  // Defaults load on reset; the write port updates one entry.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_reg[0] <= TH_DEF0;
      mem_reg[1] <= TH_DEF1;
      mem_reg[2] <= TH_DEF2_5;
      mem_reg[3] <= TH_DEF2_5;
      mem_reg[4] <= TH_DEF2_5;
      mem_reg[5] <= TH_DEF2_5;
      mem_reg[6] <= TH_DEF6_7;
      mem_reg[7] <= TH_DEF6_7;
    end
    else if (wr_en)
    begin
      mem_reg[wr_idx] <= wr_data;
    end
  end

  // Registered read port.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data <= 8'h00;
    end
    else
    begin
      rd_data <= mem_reg[rd_idx];
    end
  end

endmodule : ssmon_thresh_mem

/* File: verilog/ssmon_top.sv */
// Passive SPI snooper for the safing unit: frame check, sequence check,
// data validation, control counters and threshold store.
// Assumes the serial lines and the sync input come from pins; the serial
// clock clocks a capture domain of its own.
`timescale 1ns/1ps

// Functional notes
// - Watch four sources, each with its own chip select.
// - Examine responses only while the safing machine is in safing mode.
// - While select low, keep only the first 16 data bits.
// - Frame valid when select rises after at least 16 edges.
// - Two selects active during a frame blocks validation.
// - Message detect only when sequence counter is not 1110.
// - Mismatched sequence field against expected counter raises order mismatch.
// - Mismatch sets error flag and blocks comparison until sync edge.
// - Sample ok needs status field 01 and message detected.
// - Sample ok needs value in range and error flag clear.
// - Sequence counter counts detections, resets on sync rising edge.
// - Sequence counter loads 1111, never passes 1110.
// - Sequence counter is internal only, not reachable over serial.
// - Valid counter counts sample ok, clears on sync, reaches at most 1111.
// - Valid counter value is readable by the control command.
// - Eight 8-bit thresholds; top bit selects dwell length.
// - Sequence values 2k and 2k+1 use threshold k.
// - Thresholds reset to 0D, 95, 08 x4, 04 x2.
// - Threshold write needs start-up mode and unlock write just before.
// - Threshold data must equal unlock key XOR AD.
// - Sync rising edge marks the start of a sampling period.
module ssmon_top
  import ssmon_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic spi_sck,
  input wire logic spi_so,
  input wire logic [3:0] spi_sel_n,
  input wire logic sync_in,
  input wire logic [2:0] fsm_mode,
  input wire logic unlock_wr,
  input wire logic [7:0] unlock_data,
  input wire logic thresh_wr,
  input wire logic [2:0] thresh_wr_idx,
  input wire logic [7:0] thresh_wr_data,
  input wire logic [2:0] thresh_rd_idx,
  output logic msg_detected,
  output logic order_mismatch,
  output logic sample_ok,
  output logic order_error_flag,
  output logic compare_block,
  output logic [3:0] valid_count,
  output logic [7:0] thresh_rd_data,
  output logic [7:0] active_thresh,
  output logic active_dwell_long,
  output logic thresh_wr_done
);
  import ssmon_pkg::*;

  // ----------------------------------------------------------------
  // Link clock domain: shift register and edge counter
  // ----------------------------------------------------------------
  // The serial clock stops outside frames, so the capture state is
  // cleared by the selects themselves, never by a trailing edge.
  logic [15:0] lk_shift_reg;
  logic [4:0] lk_cnt_reg;
  logic lk_tog_reg;
  wire lk_any_sel = ~&spi_sel_n;
  wire lk_clr_n = resetn & lk_any_sel;

  always_ff @(posedge spi_sck or negedge lk_clr_n)
  begin
    if (!lk_clr_n)
    begin
      lk_shift_reg <= 16'h0000;
      lk_cnt_reg <= 5'h00;
    end
    else if (lk_cnt_reg < 5'(FRAME_BITS))
    begin
      lk_shift_reg <= {lk_shift_reg[14:0], spi_so};
      lk_cnt_reg <= lk_cnt_reg + 5'h01;
    end
  end

  // A toggle on the sixteenth edge tells the core a full word is held.
  always_ff @(posedge spi_sck or negedge resetn)
  begin
    if (!resetn)
    begin
      lk_tog_reg <= 1'b0;
    end
    else if (lk_any_sel && lk_cnt_reg == 5'(FRAME_BITS - 1))
    begin
      lk_tog_reg <= ~lk_tog_reg;
    end
  end

  // ----------------------------------------------------------------
  // Core domain synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sel_s1_reg;
  logic [3:0] sel_s2_reg;
  logic [3:0] sel_s3_reg;
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic sync_s1_reg;
  logic sync_s2_reg;
  logic sync_s3_reg;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_s1_reg <= 4'hf;
      sel_s2_reg <= 4'hf;
      sel_s3_reg <= 4'hf;
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
      sync_s1_reg <= 1'b0;
      sync_s2_reg <= 1'b0;
      sync_s3_reg <= 1'b0;
    end
    else
    begin
      sel_s1_reg <= spi_sel_n;
      sel_s2_reg <= sel_s1_reg;
      sel_s3_reg <= sel_s2_reg;
      tog_s1_reg <= lk_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
      sync_s1_reg <= sync_in;
      sync_s2_reg <= sync_s1_reg;
      sync_s3_reg <= sync_s2_reg;
    end
  end

  wire sync_rise = sync_s2_reg & ~sync_s3_reg;
  wire word_ready = tog_s2_reg ^ tog_s3_reg;
  wire [3:0] sel_act = ~sel_s2_reg;
  wire frame_active = |sel_act;
  wire frame_end = (|(~sel_s3_reg)) & ~frame_active;
  wire multi_sel = |(sel_act & (sel_act - 4'h1));

  // ----------------------------------------------------------------
  // Frame check in the core domain
  // ----------------------------------------------------------------
  logic [15:0] word_reg;
  logic word_full_reg;
  logic clash_reg;

  // The word is stable in the link domain once the toggle is seen,
  // because no further edges shift it until the select rises.
  // sixteen edges seen
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      word_reg <= 16'h0000;
      word_full_reg <= 1'b0;
    end
    else if (word_ready)
    begin
      word_reg <= lk_shift_reg;
      word_full_reg <= 1'b1;
    end
    else if (frame_end)
    begin
      word_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      clash_reg <= 1'b0;
    end
    else if (frame_end)
    begin
      clash_reg <= 1'b0;
    end
    else if (multi_sel)
    begin
      clash_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [3:0] seq_reg;
  logic [3:0] seq_next;
  logic [3:0] valid_next;
  logic err_reg;
  wire safing_mode = (fsm_mode == MODE_SAFING);
  wire [1:0] frame_status_field = word_reg[STAT_HI:STAT_LO];
  wire [2:0] order_field = word_reg[ORDER_HI:ORDER_LO];
  wire signed [9:0] sample_value = word_reg[VALUE_HI:VALUE_LO];

  wire msg_now = safing_mode & frame_end & word_full_reg & ~clash_reg
                 & ~multi_sel & (seq_reg != SEQ_FROZEN);
  always_comb
  begin
    seq_next = seq_reg + 4'h1;
  end

  wire mismatch_now = msg_now & (order_field != seq_next[2:0]);
  wire in_range = (seq_next > SEQ_WIDE_LIMIT) ?
                  (sample_value >= NARROW_MIN && sample_value <= NARROW_MAX) : 1'b1;
  wire ok_now = msg_now & (frame_status_field == STAT_SENSOR) & in_range
                & ~err_reg & ~mismatch_now;

  // Pulses are registered so every output leaves a flip-flop.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      msg_detected <= 1'b0;
      order_mismatch <= 1'b0;
      sample_ok <= 1'b0;
    end
    else
    begin
      msg_detected <= msg_now;
      order_mismatch <= mismatch_now;
      sample_ok <= ok_now;
    end
  end

  // ----------------------------------------------------------------
  // Control counters and error flag
  // ----------------------------------------------------------------
  // reset value 1111
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      seq_reg <= SEQ_RESET;
    end
    else if (sync_rise)
    begin
      seq_reg <= SEQ_RESET;
    end
    else if (msg_now)
    begin
      seq_reg <= seq_next;
    end
  end

  always_comb
  begin
    valid_next = valid_count + 4'h1;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      valid_count <= VALID_RESET;
    end
    else if (sync_rise)
    begin
      valid_count <= VALID_RESET;
    end
    else if (ok_now)
    begin
      valid_count <= valid_next;
    end
  end

  // A mismatch in the same cycle as the sync edge still sets the flag,
  // so the new period is blocked rather than the error being lost.
  // sticky error flag
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      err_reg <= 1'b0;
    end
    else if (mismatch_now)
    begin
      err_reg <= 1'b1;
    end
    else if (sync_rise)
    begin
      err_reg <= 1'b0;
    end
  end

  // Mirrors of the flag for the control readback and the comparator.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      order_error_flag <= 1'b0;
      compare_block <= 1'b0;
    end
    else
    begin
      order_error_flag <= err_reg;
      compare_block <= err_reg;
    end
  end

  // ----------------------------------------------------------------
  // Threshold logic
  // ----------------------------------------------------------------
  logic unlock_prev_reg;
  logic [7:0] unlock_key_reg;
  logic [7:0] act_rd;
  wire startup_mode = (fsm_mode == MODE_STARTUP);
  wire th_we = thresh_wr & unlock_prev_reg & startup_mode
               & (thresh_wr_data == (unlock_key_reg ^ UNLOCK_MASK));

  // Any other command breaks the unlock chain.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      unlock_prev_reg <= 1'b0;
      unlock_key_reg <= 8'h00;
    end
    else if (unlock_wr)
    begin
      unlock_prev_reg <= 1'b1;
      unlock_key_reg <= unlock_data;
    end
    else if (thresh_wr)
    begin
      unlock_prev_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      thresh_wr_done <= 1'b0;
    end
    else
    begin
      thresh_wr_done <= th_we;
    end
  end

  ssmon_thresh_mem u_rd_mem (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wr_en(th_we),
    .wr_idx(thresh_wr_idx),
    .wr_data(thresh_wr_data),
    .rd_idx(thresh_rd_idx),
    .rd_data(thresh_rd_data)
  );

  // A second copy serves the comparator so it never contends with
  // host reads; both take identical writes.
  // pair to threshold
  ssmon_thresh_mem u_act_mem (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wr_en(th_we),
    .wr_idx(thresh_wr_idx),
    .wr_data(thresh_wr_data),
    .rd_idx(seq_reg[3:1]),
    .rd_data(act_rd)
  );

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      active_thresh <= 8'h00;
      active_dwell_long <= 1'b0;
    end
    else
    begin
      active_thresh <= act_rd;
      active_dwell_long <= act_rd[DWELL_BIT];
    end
  end

endmodule : ssmon_top

/* File: tb/ssmon_top_asserts.sv */
// Port-level checker for the safing SPI monitor.
// Assumes it is bound to ssmon_top and sees one core clock domain.
`timescale 1ns/1ps
module ssmon_top_asserts
  import ssmon_pkg::*;
(
  input logic clk_sys,
  input logic resetn,
  input logic sync_in,
  input logic [2:0] fsm_mode,
  input logic unlock_wr,
  input logic [7:0] unlock_data,
  input logic thresh_wr,
  input logic [7:0] thresh_wr_data,
  input logic msg_detected,
  input logic order_mismatch,
  input logic sample_ok,
  input logic order_error_flag,
  input logic compare_block,
  input logic [3:0] valid_count,
  input logic [7:0] active_thresh,
  input logic active_dwell_long,
  input logic thresh_wr_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [2:0] calm_cnt;
  logic [7:0] key_reg;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Counter steps are only judged well away from a sync edge, which clears them.
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      calm_cnt <= 3'h0;
    else if (sync_in)
      calm_cnt <= 3'h0;
    else if (calm_cnt != 3'h7)
      calm_cnt <= calm_cnt + 3'h1;
  // Last unlock key, to judge accepted threshold writes.
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      key_reg <= 8'h00;
    else if (unlock_wr)
      key_reg <= unlock_data;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  msg_pulse_a: assert property (msg_detected |=> !msg_detected)
    else $error("msg_detected held over one cycle");
  // The pulse leaves a flip-flop, so the mode that qualified it is one cycle old.
  mode_gate_a: assert property (msg_detected |-> $past(fsm_mode) == MODE_SAFING)
    else $error("message detected outside safing mode");
  ok_clean_a: assert property (sample_ok |->
    msg_detected && !order_mismatch && !order_error_flag)
    else $error("sample_ok without clean message");
  mismatch_flag_a: assert property (order_mismatch |-> msg_detected ##1 order_error_flag)
    else $error("mismatch did not set the error flag");
  block_follow_a: assert property (compare_block == order_error_flag)
    else $error("compare_block differs from error flag");
  // The count steps on the same edge that raises sample_ok.
  vcount_step_a: assert property (sample_ok && calm_cnt > 3'h4 |->
    valid_count == $past(valid_count) + 4'h1)
    else $error("valid_count did not step");
  vcount_hold_a: assert property (!sample_ok && calm_cnt > 3'h4 |-> $stable(valid_count))
    else $error("valid_count moved without sample_ok");
  sync_clear_a: assert property ($rose(sync_in) |-> ##[1:4] valid_count == 4'h0 && !order_error_flag)
    else $error("sync edge did not clear state");
  done_mode_a: assert property (thresh_wr_done |->
    $past(thresh_wr) && $past(fsm_mode) == MODE_STARTUP)
    else $error("threshold write accepted outside start-up");
  done_key_a: assert property (thresh_wr_done |->
    $past(thresh_wr_data) == ($past(key_reg) ^ UNLOCK_MASK))
    else $error("threshold write accepted with wrong key");
  dwell_bit_a: assert property (active_dwell_long == active_thresh[DWELL_BIT])
    else $error("dwell select differs from threshold top bit");
endmodule : ssmon_top_asserts

bind ssmon_top ssmon_top_asserts u_chk (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .sync_in(sync_in),
  .fsm_mode(fsm_mode),
  .unlock_wr(unlock_wr),
  .unlock_data(unlock_data),
  .thresh_wr(thresh_wr),
  .thresh_wr_data(thresh_wr_data),
  .msg_detected(msg_detected),
  .order_mismatch(order_mismatch),
  .sample_ok(sample_ok),
  .order_error_flag(order_error_flag),
  .compare_block(compare_block),
  .valid_count(valid_count),
  .active_thresh(active_thresh),
  .active_dwell_long(active_dwell_long),
  .thresh_wr_done(thresh_wr_done)
);

/* File: tb/ssmon_spi_model.sv */
// Sensor-side serial model: one 48 ns clock, MSB first, four selects.
// Assumes the bench calls send and leaves gaps between frames.
`timescale 1ns/1ps
module ssmon_spi_model (
  output logic sck,
  output logic so,
  output logic [3:0] sel_n
);
  initial
  begin
    sck = 1'b0;
    so = 1'b1;
    sel_n = 4'hf;
  end
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  // The clock stands still between frames; released data shows the inverse.
  task automatic send(input logic [1:0] src, input logic [15:0] w, input int e, input logic d);
    #3;
    sel_n[src] = 1'b0;
    if (d)
      sel_n[src + 2'h1] = 1'b0;
    for (int i = 0; i < e; i++)
    begin
      so = (i < 16) ? w[15 - i] : ~so;
      #24 sck = 1'b1;
      #24 sck = 1'b0;
    end
    #24 sel_n = 4'hf;
    so = ~so;
    #48;
  endtask : send
endmodule : ssmon_spi_model

/* File: tb/tb_ssmon_top.sv */
// Self-checking bench for the safing SPI monitor.
// Assumes the package, design, link model and checker are compiled first.
`timescale 1ns/1ps
module tb_ssmon_top;
  import ssmon_pkg::*;
  typedef struct {
    logic [1:0] src, st;
    logic [2:0] ord;
    logic [9:0] val;
    int e;
    logic d;
    logic [2:0] mxo;
    logic [3:0] vc;
    logic fl;
  } ssmon_row_t;
  logic clk_sys, resetn, spi_sck, spi_so, sync_in, unlock_wr, thresh_wr;
  logic msg_detected, order_mismatch, sample_ok, order_error_flag, compare_block;
  logic active_dwell_long, thresh_wr_done;
  logic [3:0] spi_sel_n, valid_count;
  logic [2:0] fsm_mode, thresh_wr_idx, thresh_rd_idx;
  logic [7:0] unlock_data, thresh_wr_data, thresh_rd_data, active_thresh;
  int n_msg, n_mis, n_ok, error_cnt, checked;
  logic [7:0] defs [8] = '{8'h0d, 8'h95, 8'h08, 8'h08, 8'h08, 8'h08, 8'h04, 8'h04};
  // Frames in host order from one sync edge; mxo is expected msg, mismatch, ok.
  // full order
  ssmon_row_t rows [10] = '{
    '{2'h0, 2'h1, 3'h0, 10'h005, 16, 1'b0, 3'h5, 4'h1, 1'b0},
    '{2'h1, 2'h1, 3'h1, 10'h1ff, 20, 1'b0, 3'h5, 4'h2, 1'b0},
    '{2'h2, 2'h1, 3'h2, 10'h000, 15, 1'b0, 3'h0, 4'h2, 1'b0},
    '{2'h3, 2'h1, 3'h2, 10'h000, 16, 1'b1, 3'h0, 4'h2, 1'b0},
    '{2'h2, 2'h1, 3'h2, 10'h200, 16, 1'b0, 3'h5, 4'h3, 1'b0},
    '{2'h0, 2'h1, 3'h3, 10'h1e1, 16, 1'b0, 3'h4, 4'h3, 1'b0},
    '{2'h0, 2'h2, 3'h4, 10'h000, 16, 1'b0, 3'h4, 4'h3, 1'b0},
    '{2'h1, 2'h1, 3'h5, 10'h220, 16, 1'b0, 3'h5, 4'h4, 1'b0},
    '{2'h3, 2'h1, 3'h7, 10'h000, 16, 1'b0, 3'h6, 4'h4, 1'b1},
    '{2'h0, 2'h1, 3'h7, 10'h000, 16, 1'b0, 3'h4, 4'h4, 1'b1}};

  ssmon_top DUT (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .spi_sck(spi_sck),
    .spi_so(spi_so),
    .spi_sel_n(spi_sel_n),
    .sync_in(sync_in),
    .fsm_mode(fsm_mode),
    .unlock_wr(unlock_wr),
    .unlock_data(unlock_data),
    .thresh_wr(thresh_wr),
    .thresh_wr_idx(thresh_wr_idx),
    .thresh_wr_data(thresh_wr_data),
    .thresh_rd_idx(thresh_rd_idx),
    .msg_detected(msg_detected),
    .order_mismatch(order_mismatch),
    .sample_ok(sample_ok),
    .order_error_flag(order_error_flag),
    .compare_block(compare_block),
    .valid_count(valid_count),
    .thresh_rd_data(thresh_rd_data),
    .active_thresh(active_thresh),
    .active_dwell_long(active_dwell_long),
    .thresh_wr_done(thresh_wr_done)
  );
  ssmon_spi_model spi (
    .sck(spi_sck),
    .so(spi_so),
    .sel_n(spi_sel_n)
  );

  // ----------------------------------------------------------------
  // Clock, pulse tally and helpers
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Pulses last one cycle, so counting them judges each frame exactly.
  always @(posedge clk_sys)
  begin
    if (msg_detected === 1'b1) n_msg++;
    if (order_mismatch === 1'b1) n_mis++;
    if (sample_ok === 1'b1) n_ok++;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic frame(input logic [1:0] src, input logic [15:0] w, input int e, input logic d,
                       input logic [2:0] mxo);
    int m0, x0, o0;
    m0 = n_msg;
    x0 = n_mis;
    o0 = n_ok;
    spi.send(src, w, e, d);
    repeat (6) @(posedge clk_sys);
    check("msg_detected", 16'(n_msg - m0), 16'(mxo[2]));
    check("order_mismatch", 16'(n_mis - x0), 16'(mxo[1]));
    check("sample_ok", 16'(n_ok - o0), 16'(mxo[0]));
  endtask : frame
  task automatic sync_pulse();
    sync_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sync_in <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : sync_pulse
  task automatic twr(input logic [2:0] md, input logic ul, input logic [2:0] idx,
                     input logic [7:0] key, input logic [7:0] d, input logic ok,
                     input logic [7:0] want);
    @(posedge clk_sys);
    fsm_mode <= md;
    unlock_wr <= ul;
    unlock_data <= key;
    @(posedge clk_sys);
    unlock_wr <= 1'b0;
    thresh_wr <= 1'b1;
    thresh_wr_idx <= idx;
    thresh_wr_data <= d;
    thresh_rd_idx <= idx;
    @(posedge clk_sys);
    thresh_wr <= 1'b0;
    @(posedge clk_sys);
    check("thresh_wr_done", 16'(thresh_wr_done), 16'(ok));
    repeat (3) @(posedge clk_sys);
    check("thresh_rd_data", 16'(thresh_rd_data), 16'(want));
  endtask : twr
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  initial
  begin
    #500000;
    error_cnt++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    // Reset falls after time zero so every asynchronous reset sees a clean edge.
    {resetn, sync_in, unlock_wr, thresh_wr} = 4'h8;
    #2;
    resetn = 1'b0;
    {unlock_data, thresh_wr_data, thresh_wr_idx, thresh_rd_idx} = 22'h0;
    fsm_mode = MODE_SAFING;
    repeat (6) @(posedge clk_sys);
    check("valid_count", 16'(valid_count), 16'h0);
    check("order_error_flag", 16'(order_error_flag), 16'h0);
    resetn <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk_sys);
      thresh_rd_idx <= 3'(k);
      repeat (3) @(posedge clk_sys);
      check("thresh_rd_data", 16'(thresh_rd_data), 16'(defs[k]));
    end
    check("active_thresh", 16'(active_thresh), 16'h04);
    // A short frame first; its select release also clears whatever the link capture held.
    frame(2'h1, 16'h4000, 4, 1'b0, 3'h0);
    sync_pulse();
    foreach (rows[i])
    begin
      frame(rows[i].src, {rows[i].st, rows[i].ord, 1'b0, rows[i].val}, rows[i].e, rows[i].d,
            rows[i].mxo);
      check("valid_count", 16'(valid_count), 16'(rows[i].vc));
      check("order_error_flag", 16'(order_error_flag), 16'(rows[i].fl));
    end
    sync_pulse();
    check("valid_count", 16'(valid_count), 16'h0);
    check("order_error_flag", 16'(order_error_flag), 16'h0);
    fsm_mode <= MODE_STARTUP;
    frame(2'h0, 16'h4000, 16, 1'b0, 3'h0);
    fsm_mode <= MODE_SAFING;
    // Fifteen frames reach the frozen count; the sixteenth must be ignored.
    for (int i = 0; i < 16; i++)
      frame(2'h0, {2'h1, 3'(i), 11'h0}, 16, 1'b0, (i < 15) ? 3'h5 : 3'h0);
    check("valid_count", 16'(valid_count), 16'h000f);
    twr(MODE_STARTUP, 1'b1, 3'h2, 8'h5a, 8'hf7, 1'b1, 8'hf7);
    twr(MODE_STARTUP, 1'b1, 3'h3, 8'h11, 8'h11, 1'b0, 8'h08);
    twr(MODE_STARTUP, 1'b0, 3'h3, 8'h11, 8'hbc, 1'b0, 8'h08);
    twr(MODE_SAFING, 1'b1, 3'h4, 8'h22, 8'h8f, 1'b0, 8'h08);
    twr(MODE_STARTUP, 1'b1, 3'h7, 8'h6e, 8'hc3, 1'b1, 8'hc3);
    check("active_thresh", 16'(active_thresh), 16'h00c3);
    check("active_dwell_long", 16'(active_dwell_long), 16'h1);
    // A reset in mid-run must restore the defaults even after accepted writes.
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check("valid_count", 16'(valid_count), 16'h0);
    resetn <= 1'b1;
    fsm_mode <= MODE_SAFING;
    thresh_rd_idx <= 3'h2;
    repeat (4) @(posedge clk_sys);
    check("thresh_rd_data", 16'(thresh_rd_data), 16'h08);
    check("active_thresh", 16'(active_thresh), 16'h04);
    frame(2'h0, {2'h1, 3'h0, 11'h0}, 16, 1'b0, 3'h5);
    check("valid_count", 16'(valid_count), 16'h1);
    conclude();
  end
endmodule : tb_ssmon_top
